// >>> shared/ide_dma_params.svh
`ifndef IDE_DMA_PARAMS_SVH
`define IDE_DMA_PARAMS_SVH

// Word indices of the register port (byte address bits 7:2).
`define IDE_DMA_WORD_PRIMARY 6'h00
`define IDE_DMA_WORD_SECONDARY 6'h02

// Byte offsets of the four 16-bit registers.
`define IDE_DMA_OFF_CMD_PRI 8'h00
`define IDE_DMA_OFF_STAT_PRI 8'h02
`define IDE_DMA_OFF_CMD_SEC 8'h08
`define IDE_DMA_OFF_STAT_SEC 8'h0A

// Byte enable lanes inside the primary word.
`define IDE_DMA_LANE_CMD_LO 0
`define IDE_DMA_LANE_CMD_HI 1
`define IDE_DMA_LANE_STAT_LO 2
`define IDE_DMA_LANE_STAT_HI 3

// Command register fields.
`define IDE_DMA_CMD_GO_BIT 0
`define IDE_DMA_CMD_DIR_BIT 3

// Status register fields.
`define IDE_DMA_ST_ACTIVE_BIT 0
`define IDE_DMA_ST_FAULT_BIT 1
`define IDE_DMA_ST_DRIVE_BIT 2
`define IDE_DMA_ST_TABLE_END_BIT 4
`define IDE_DMA_ST_MASTER_CAP_BIT 5
`define IDE_DMA_ST_SLAVE_CAP_BIT 6
`define IDE_DMA_ST_BUS_ERR_BIT 8

// Reset values.
`define IDE_DMA_CMD_RESET 16'h0000
`define IDE_DMA_STAT_RESET 16'h0000

`endif

// >>> shared/ide_dma_pkg.sv
package ide_dma_pkg;

    // Engine sequencing seen by the control and status registers.
    typedef enum logic [1:0] {
        st_idle,
        st_run,
        st_ended
    } engine_state_t;

    // State of the control and status block, all but the two reset synchroniser flip-flops.
    typedef struct packed {
        engine_state_t state;
        logic go;
        logic dir;
        logic active;
        logic fault;
        logic drive_flag;
        logic table_end;
        logic bus_err;
        logic master_cap;
        logic slave_cap;
        logic irq_meta;
        logic irq_sync;
        logic irq_prev;
        logic start_pulse;
        logic abort_pulse;
        logic [31:0] rdata;
    } ctrl_state_t;

endpackage

// >>> core/ide_dma_ctrl_status.sv
// What this block does
// - Writing go bit one launches the engine.
// - Writing go bit zero ends transfer; no resume.
// - Go bit stays one after normal completion.
// - Zero while active aborts the running transaction.
// - Direction bit three: zero to drive, one from.
// - Secondary registers read zero, ignore writes.
// - Byte, halfword and combined word accesses accepted.
// - Writing go one sets the active flag.
// - Active clears when last descriptor finishes.
// - Active clears when software aborts the transfer.
// - Equal sizes, no table interrupt: 0,1,0.
// - Larger table: drive flag set, active stays.
// - Smaller table, no table interrupt: all zero.
// - Equal sizes with table interrupt: 1,1,0.
// - Smaller table with table interrupt: 1,0,0.
// - Fault flag set only by buffer over/underflow.
// - Fault flag cleared by writing one.
// - Drive flag: drive edge or transfer end; W1C.
// - Table end flag on last descriptor, if enabled.
//
// Our own choice: the address-and-strobe port.
`timescale 1ns/100ps
`include "ide_dma_params.svh"

module ide_dma_ctrl_status #(
    parameter int ADDR_W = 8
) (
    // Clock and reset.
    input wire logic mclk,
    input wire logic resetn,
    // Register port.
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [3:0] reg_be,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // Reports from the transfer datapath, same clock.
    input wire logic desc_done,
    input wire logic desc_last,
    input wire logic buf_fault,
    input wire logic bus_fault,
    input wire logic xfer_done,
    input wire logic table_end_irq_enable,
    // Interrupt line of the drive, asynchronous pin.
    input wire logic drive_irq,
    // Controls to the transfer datapath.
    output logic engine_start,
    output logic engine_abort,
    output logic engine_running,
    output logic transfer_direction
);

    logic rst_meta;
    logic rst_n;
    ide_dma_pkg::ctrl_state_t q;
    ide_dma_pkg::ctrl_state_t next_q;
    logic word_primary;
    logic word_secondary;
    logic cmd_wr;
    logic stat_lo_wr;
    logic stat_hi_wr;
    logic drive_rise;

    // Packs the command register image; unused bits stay zero.
    function automatic logic [15:0] cmd_image(input ide_dma_pkg::ctrl_state_t s);
        logic [15:0] v;
        v = `IDE_DMA_CMD_RESET;
        v[`IDE_DMA_CMD_GO_BIT] = s.go;
        v[`IDE_DMA_CMD_DIR_BIT] = s.dir;
        return v;
    endfunction

    // Packs the status register image; the simplex bit and the other reserved bits read zero.
    function automatic logic [15:0] status_image(input ide_dma_pkg::ctrl_state_t s);
        logic [15:0] v;
        v = `IDE_DMA_STAT_RESET;
        v[`IDE_DMA_ST_ACTIVE_BIT] = s.active;
        v[`IDE_DMA_ST_FAULT_BIT] = s.fault;
        v[`IDE_DMA_ST_DRIVE_BIT] = s.drive_flag;
        v[`IDE_DMA_ST_TABLE_END_BIT] = s.table_end;
        v[`IDE_DMA_ST_MASTER_CAP_BIT] = s.master_cap;
        v[`IDE_DMA_ST_SLAVE_CAP_BIT] = s.slave_cap;
        v[`IDE_DMA_ST_BUS_ERR_BIT] = s.bus_err;
        return v;
    endfunction

    // Reset is asserted at once and released through two flip-flops.
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            rst_meta <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n <= rst_meta;
        end
    end

    // Address decode: the primary word holds command and status side by side.
    assign word_primary = (reg_addr[7:2] == `IDE_DMA_WORD_PRIMARY);
    assign word_secondary = (reg_addr[7:2] == `IDE_DMA_WORD_SECONDARY);
    assign cmd_wr = reg_wr && word_primary && reg_be[`IDE_DMA_LANE_CMD_LO];
    assign stat_lo_wr = reg_wr && word_primary && reg_be[`IDE_DMA_LANE_STAT_LO];
    assign stat_hi_wr = reg_wr && word_primary && reg_be[`IDE_DMA_LANE_STAT_HI];

    // A rising edge on the synchronised drive line; the first stage is not looked at.
    assign drive_rise = q.irq_sync && !q.irq_prev;

    // Next-state logic of the whole block.
    always_comb begin
        logic new_go;
        logic w1c_fault;
        logic w1c_drive;
        logic w1c_table;
        logic w1c_bus;
        logic set_fault;
        logic set_drive;
        logic set_table;
        logic set_bus;
        logic last_done;
        new_go = reg_wdata[`IDE_DMA_CMD_GO_BIT];
        next_q = q;
        next_q.start_pulse = 1'b0;
        next_q.abort_pulse = 1'b0;
        next_q.irq_meta = drive_irq;
        next_q.irq_sync = q.irq_meta;
        next_q.irq_prev = q.irq_sync;
        last_done = q.active && desc_done && desc_last;

        // Write-one-to-clear requests from the status byte lanes.
        w1c_fault = stat_lo_wr && reg_wdata[16 + `IDE_DMA_ST_FAULT_BIT];
        w1c_drive = stat_lo_wr && reg_wdata[16 + `IDE_DMA_ST_DRIVE_BIT];
        w1c_table = stat_lo_wr && reg_wdata[16 + `IDE_DMA_ST_TABLE_END_BIT];
        w1c_bus = stat_hi_wr && reg_wdata[16 + `IDE_DMA_ST_BUS_ERR_BIT];

        // Hardware events; each set beats a clear in the same cycle.
        set_fault = q.active && buf_fault;
        set_drive = drive_rise || (q.active && xfer_done);
        set_table = last_done && table_end_irq_enable;
        set_bus = q.active && bus_fault;

        if (set_fault) begin
            next_q.fault = 1'b1;
        end else if (w1c_fault) begin
            next_q.fault = 1'b0;
        end
        if (set_drive) begin
            next_q.drive_flag = 1'b1;
        end else if (w1c_drive) begin
            next_q.drive_flag = 1'b0;
        end
        if (set_table) begin
            next_q.table_end = 1'b1;
        end else if (w1c_table) begin
            next_q.table_end = 1'b0;
        end
        if (set_bus) begin
            next_q.bus_err = 1'b1;
        end else if (w1c_bus) begin
            next_q.bus_err = 1'b0;
        end

        // Software-owned capability bits have no effect on the engine.
        if (stat_lo_wr) begin
            next_q.master_cap = reg_wdata[16 + `IDE_DMA_ST_MASTER_CAP_BIT];
            next_q.slave_cap = reg_wdata[16 + `IDE_DMA_ST_SLAVE_CAP_BIT];
        end

        // Engine sequencing. A drive interrupt alone never ends the run, so a table
        // larger than the drive transfer leaves the engine active.
        unique case (q.state)
            ide_dma_pkg::st_idle, ide_dma_pkg::st_ended: begin
                if (cmd_wr && new_go && !q.go) begin
                    next_q.state = ide_dma_pkg::st_run;
                    next_q.active = 1'b1;
                    next_q.start_pulse = 1'b1;
                end
            end
            ide_dma_pkg::st_run: begin
                if (cmd_wr && !new_go) begin
                    next_q.state = ide_dma_pkg::st_idle;
                    next_q.active = 1'b0;
                    next_q.abort_pulse = 1'b1;
                end else if (last_done) begin
                    // Table exhausted: with equal sizes the drive flag comes from the
                    // transfer end, with a short table it stays clear.
                    next_q.state = ide_dma_pkg::st_ended;
                    next_q.active = 1'b0;
                end
            end
        endcase

        // The go bit only follows software; completion leaves it at one.
        if (cmd_wr) begin
            next_q.go = new_go;
            next_q.dir = reg_wdata[`IDE_DMA_CMD_DIR_BIT];
        end

        // Read data stand for exactly the cycle after the read strobe.
        next_q.rdata = 32'h0000_0000;
        if (reg_rd && word_primary) begin
            next_q.rdata = {status_image(q), cmd_image(q)};
        end else if (reg_rd && word_secondary) begin
            next_q.rdata = 32'h0000_0000;
        end
    end

    // State register.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            q <= '{state: ide_dma_pkg::st_idle, rdata: 32'h0000_0000, default: 1'b0};
        end else begin
            q <= next_q;
        end
    end

    // Outputs come straight from the state register.
    assign reg_rdata = q.rdata;
    assign engine_start = q.start_pulse;
    assign engine_abort = q.abort_pulse;
    assign engine_running = q.active;
    assign transfer_direction = q.dir;

    // Checks of the register behaviour, all on the system clock.
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_n);

    // A write of one to the go bit while it is clear.
    sequence seq_go_set;
        cmd_wr && reg_wdata[`IDE_DMA_CMD_GO_BIT] && !q.go;
    endsequence

    // A write of zero to the go bit while the engine runs.
    sequence seq_go_clear_active;
        cmd_wr && !reg_wdata[`IDE_DMA_CMD_GO_BIT] && q.active;
    endsequence

    // The last descriptor finishing while no stop is written.
    sequence seq_last_done;
        q.active && desc_done && desc_last && !cmd_wr;
    endsequence

    a_start_sets_active: assert property (seq_go_set |=> engine_start && engine_running ##1 !engine_start)
        else $error("Start write did not raise active for one start pulse.");

    a_stop_aborts: assert property (seq_go_clear_active |=> engine_abort && !engine_running && !q.go)
        else $error("Stop write while active did not abort.");

    a_completion_keeps_go: assert property (seq_last_done |=> !engine_running && q.go)
        else $error("Completion cleared the go bit or left active set.");

    a_no_restart: assert property (engine_running && !cmd_wr && !(desc_done && desc_last) |=> engine_running)
        else $error("Active dropped without stop or last descriptor.");

    a_table_end_gate: assert property ($rose(q.table_end) |-> $past(desc_last && desc_done && table_end_irq_enable))
        else $error("Table end flag set without an enabled last descriptor.");

    a_fault_cause: assert property ($rose(q.fault) |-> $past(buf_fault && q.active))
        else $error("Fault flag set without a buffer fault.");

    a_fault_clear: assert property (w1c_check_fault() |=> !q.fault)
        else $error("Writing one did not clear the fault flag.");

    a_drive_edge: assert property (drive_rise |=> q.drive_flag)
        else $error("Drive edge was not captured.");

    a_secondary_zero: assert property (reg_rd && word_secondary |=> reg_rdata == 32'h0000_0000)
        else $error("Secondary registers did not read zero.");

    a_reserved_zero: assert property (reg_rd && word_primary |=> reg_rdata[15:4] == 12'h000 && reg_rdata[2:1] == 2'b00
        && reg_rdata[31:25] == 7'h00 && reg_rdata[23] == 1'b0)
        else $error("Reserved bits did not read zero.");

    // A stop write while the engine is not running.
    sequence seq_go_clear_idle;
        cmd_wr && !reg_wdata[`IDE_DMA_CMD_GO_BIT] && !q.active;
    endsequence

    // A read of the combined primary word.
    sequence seq_primary_read;
        reg_rd && word_primary;
    endsequence

    // A primary write that leaves the command low lane out.
    sequence seq_lane_skip;
        reg_wr && word_primary && !reg_be[`IDE_DMA_LANE_CMD_LO];
    endsequence

    // A last descriptor finishing while table end reporting is off.
    sequence seq_last_unreported;
        q.active && desc_done && desc_last && !table_end_irq_enable && !q.table_end;
    endsequence

    a_start_once: assert property (engine_start |=> !engine_start)
        else $error("Start pulse lasted more than one cycle.");

    a_abort_once: assert property (engine_abort |-> !engine_running ##1 !engine_abort)
        else $error("Abort pulse was not a single cycle with the engine stopped.");

    a_idle_stop: assert property (seq_go_clear_idle |=> !engine_abort && !engine_running)
        else $error("Stop write while idle produced an abort or a run.");

    a_start_needs_clear: assert property (cmd_wr && reg_wdata[`IDE_DMA_CMD_GO_BIT] && q.go |=> !engine_start)
        else $error("Start write with the go bit already set relaunched the engine.");

    a_go_kept: assert property (!cmd_wr |=> $stable(q.go))
        else $error("Go bit changed without a command write.");

    a_dir_follows: assert property (cmd_wr |=> transfer_direction == $past(reg_wdata[`IDE_DMA_CMD_DIR_BIT]))
        else $error("Direction output did not follow the command write.");

    a_active_source: assert property ($rose(engine_running) |-> $past(cmd_wr && reg_wdata[`IDE_DMA_CMD_GO_BIT]))
        else $error("Active flag rose without a start write.");

    a_drive_cause: assert property ($rose(q.drive_flag) |-> $past(drive_rise || (q.active && xfer_done)))
        else $error("Drive flag set without a drive edge or transfer end.");

    a_drive_clear: assert property (w1c_check_drive() |=> !q.drive_flag)
        else $error("Writing one did not clear the drive flag.");

    a_table_clear: assert property (w1c_check_table() |=> !q.table_end)
        else $error("Writing one did not clear the table end flag.");

    a_table_gate_off: assert property (seq_last_unreported |=> !q.table_end)
        else $error("Table end flag set while its reporting was disabled.");

    a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 32'h0000_0000)
        else $error("Read data stood outside the cycle after a read.");

    a_cmd_readback: assert property (seq_primary_read |=> reg_rdata[`IDE_DMA_CMD_GO_BIT] == $past(q.go)
        && reg_rdata[`IDE_DMA_CMD_DIR_BIT] == $past(q.dir))
        else $error("Command half of the combined word read wrong.");

    a_status_readback: assert property (seq_primary_read |=> reg_rdata[16 + `IDE_DMA_ST_ACTIVE_BIT] == $past(q.active)
        && reg_rdata[16 + `IDE_DMA_ST_FAULT_BIT] == $past(q.fault)
        && reg_rdata[16 + `IDE_DMA_ST_DRIVE_BIT] == $past(q.drive_flag)
        && reg_rdata[16 + `IDE_DMA_ST_TABLE_END_BIT] == $past(q.table_end))
        else $error("Status half of the combined word read wrong.");

    a_lane_skip: assert property (seq_lane_skip |=> $stable(q.go) && $stable(q.dir))
        else $error("Command bits changed without their byte lane.");

    a_secondary_write: assert property (reg_wr && word_secondary |=> $stable(q.go) && $stable(q.dir)
        && $stable(q.master_cap) && $stable(q.slave_cap))
        else $error("A secondary write changed a primary register.");

    // A clear of the fault flag with no fault arriving in the same cycle.
    function automatic logic w1c_check_fault();
        return stat_lo_wr && reg_wdata[16 + `IDE_DMA_ST_FAULT_BIT] && !(buf_fault && q.active);
    endfunction

    // A clear of the drive flag with no drive event in the same cycle.
    function automatic logic w1c_check_drive();
        return stat_lo_wr && reg_wdata[16 + `IDE_DMA_ST_DRIVE_BIT] && !drive_rise && !(q.active && xfer_done);
    endfunction

    // A clear of the table end flag with no reported last descriptor in the same cycle.
    function automatic logic w1c_check_table();
        return stat_lo_wr && reg_wdata[16 + `IDE_DMA_ST_TABLE_END_BIT]
            && !(q.active && desc_done && desc_last && table_end_irq_enable);
    endfunction

endmodule // ide_dma_ctrl_status

// >>> bench/drive_model.sv
`timescale 1ns/100ps
module drive_model (
    // Clock.
    input wire logic mclk,
    // Engine controls seen by the drive side.
    input wire logic engine_start,
    input wire logic engine_running,
    // Sizes of the table and of the drive transfer, in descriptors.
    input wire logic [3:0] table_len,
    input wire logic [3:0] drive_len,
    // Reports of the transfer.
    output logic desc_done,
    output logic desc_last,
    output logic xfer_done,
    output logic drive_irq
);
    logic [3:0] n;
    logic [1:0] pace;
    logic busy;

    // Everything starts quiet.
    initial begin
        {desc_done, desc_last, xfer_done, drive_irq, busy, n, pace} = '0;
    end

    // One descriptor every four cycles; the drive stops when its own count or the table runs out.
    always @(posedge mclk) begin
        desc_done <= 1'b0;
        desc_last <= 1'b0;
        xfer_done <= 1'b0;
        if (engine_start === 1'b1) begin
            busy <= 1'b1;
            n <= 4'h0;
            pace <= 2'h0;
            drive_irq <= 1'b0;
        end else if (busy && engine_running !== 1'b1) begin
            busy <= 1'b0;
        end else if (busy) begin
            pace <= pace + 2'h1;
            if (pace == 2'h3) begin
                n <= n + 4'h1;
                desc_done <= 1'b1;
                desc_last <= (n + 4'h1 == table_len);
                if (n + 4'h1 == drive_len) begin
                    xfer_done <= 1'b1;
                    drive_irq <= 1'b1;
                end
                if (n + 4'h1 == table_len || n + 4'h1 == drive_len) begin
                    busy <= 1'b0;
                end
            end
        end
    end
endmodule // drive_model

// >>> bench/testbench.sv
`timescale 1ns/100ps
module testbench;
    logic mclk = 1'b0;
    logic resetn = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [3:0] reg_be = 4'h0;
    logic [31:0] reg_wdata = 32'h00000000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    logic desc_done, desc_last, xfer_done, drive_irq;
    logic buf_fault = 1'b0;
    logic bus_fault = 1'b0;
    logic table_end_irq_enable = 1'b0;
    logic engine_start, engine_abort, engine_running, transfer_direction;
    logic [3:0] table_len = 4'h0;
    logic [3:0] drive_len = 4'h0;
    logic [31:0] rv;
    int fail_count = 0;
    int checks_done = 0;
    int starts = 0;
    int aborts = 0;

    // Clock of 5 ns period.
    always #2.5 mclk = ~mclk;

    ide_dma_ctrl_status uut (.mclk(mclk), .resetn(resetn), .reg_addr(reg_addr), .reg_be(reg_be),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .desc_done(desc_done),
        .desc_last(desc_last), .buf_fault(buf_fault), .bus_fault(bus_fault), .xfer_done(xfer_done),
        .table_end_irq_enable(table_end_irq_enable), .drive_irq(drive_irq), .engine_start(engine_start),
        .engine_abort(engine_abort), .engine_running(engine_running), .transfer_direction(transfer_direction));

    drive_model drive (.mclk(mclk), .engine_start(engine_start), .engine_running(engine_running),
        .table_len(table_len), .drive_len(drive_len), .desc_done(desc_done), .desc_last(desc_last),
        .xfer_done(xfer_done), .drive_irq(drive_irq));

    // Counts launch and abort pulses of the engine.
    always @(posedge mclk) begin
        if (engine_start === 1'b1) starts++;
        if (engine_abort === 1'b1) aborts++;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic conclude;
        $display("Comparisons %0d, mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_be <= be;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
        @(negedge mclk);
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        @(negedge mclk);
        d = reg_rdata;
    endtask

    // Waits until the engine stops or the drive interrupts, then lets the pin synchroniser settle.
    task automatic wait_end;
        int i;
        repeat (2) @(posedge mclk);
        for (i = 0; i < 200 && engine_running === 1'b1 && drive_irq !== 1'b1; i++) @(posedge mclk);
        if (i == 200) begin
            fail_count++;
            $display("[ERR] %0t transfer never ended", $time);
            conclude();
        end
        repeat (8) @(posedge mclk);
    endtask

    task automatic pulse(input logic buffer_side);
        @(posedge mclk);
        buf_fault <= buffer_side;
        bus_fault <= ~buffer_side;
        @(posedge mclk);
        buf_fault <= 1'b0;
        bus_fault <= 1'b0;
    endtask

    // Reset values, secondary and unmapped words, lanes and reserved bits.
    task automatic s_regs;
        rd(8'h00, rv);
        check(rv, 32'h00000000);
        wr(8'h08, 4'hF, 32'hFFFFFFFF);
        rd(8'h08, rv);
        check(rv, 32'h00000000);
        rd(8'h40, rv);
        check(rv, 32'h00000000);
        wr(8'h00, 4'h1, 32'h000000FE);
        check(engine_running, 32'h0);
        check(transfer_direction, 32'h1);
        wr(8'h00, 4'h2, 32'h0000FF00);
        wr(8'h00, 4'h4, 32'h00EC0000);
        rd(8'h00, rv);
        check(rv, 32'h00600008);
        wr(8'h00, 4'hF, 32'h00000000);
        rd(8'h00, rv);
        check(rv, 32'h00000000);
        check(transfer_direction, 32'h0);
    endtask

    // One transfer with given sizes; expected {table end, drive, active} at termination.
    task automatic s_run(input logic [3:0] tl, input logic [3:0] dl, input logic en, input logic [2:0] exp);
        @(posedge mclk);
        table_len <= tl;
        drive_len <= dl;
        table_end_irq_enable <= en;
        // Direction travels with the go write.
        wr(8'h00, 4'h1, 32'h00000009);
        check(engine_running, 32'h1);
        check(transfer_direction, 32'h1);
        wait_end();
        rd(8'h00, rv);
        check({rv[20], rv[18], rv[16]}, exp);
        check(rv[17], 32'h0);
        check(rv[0], 32'h1);
        wr(8'h00, 4'h1, 32'h00000008);
        check(engine_running, 32'h0);
        wr(8'h00, 4'h4, 32'h00170000);
        rd(8'h00, rv);
        check(rv[31:16], 32'h0);
    endtask

    // Abort in mid-transfer, fresh start, then the fault flags.
    task automatic s_abort;
        int a0;
        int s0;
        a0 = aborts;
        s0 = starts;
        @(posedge mclk);
        table_len <= 4'hF;
        drive_len <= 4'hF;
        wr(8'h00, 4'h1, 32'h00000009);
        repeat (6) @(posedge mclk);
        wr(8'h00, 4'h1, 32'h00000008);
        check(engine_running, 32'h0);
        // The pulse counter samples one edge after the write is taken.
        @(negedge mclk);
        check(32'(aborts - a0), 32'h1);
        repeat (30) @(posedge mclk);
        rd(8'h00, rv);
        check(rv[20:16], 32'h0);
        wr(8'h00, 4'h1, 32'h00000009);
        @(negedge mclk);
        check(32'(starts - s0), 32'h2);
        pulse(1'b0);
        rd(8'h00, rv);
        check({rv[24], rv[17]}, 32'h2);
        pulse(1'b1);
        wr(8'h00, 4'h4, 32'h00000000);
        rd(8'h00, rv);
        check(rv[17], 32'h1);
        wr(8'h00, 4'h4, 32'h00020000);
        rd(8'h00, rv);
        check(rv[17], 32'h0);
        wr(8'h00, 4'h1, 32'h00000008);
    endtask

    // Main sequence.
    initial begin
        repeat (20) @(posedge mclk);
        resetn <= 1'b1;
        repeat (3) @(posedge mclk);
        s_regs();
        s_run(4'h2, 4'h2, 1'b0, 3'b010);
        s_run(4'h3, 4'h2, 1'b0, 3'b011);
        s_run(4'h1, 4'h2, 1'b0, 3'b000);
        s_run(4'h2, 4'h2, 1'b1, 3'b110);
        s_run(4'h1, 4'h3, 1'b1, 3'b100);
        s_abort();
        conclude();
    end
endmodule // testbench
